// file: src/adc_bus_pkg.sv
// Behaviour
// - Start gating by chip select in clocked mode.
// - conv_done low while converting, high after.
// - Unclocked mode: conv_done open drain, enable-gated.
// - Clocked mode: conv_done three-state, select-gated.
// - Result bits driven only with select and enable.
// - 8-bit mode: two low pins are format inputs.
// - Unipolar straight binary, bipolar twos complement.
// - Register keeps old result until update delay.
// - Register refreshes only after reset or an output enable toggle.
// - 8-bit reads: high byte then low byte.
// - Byte select low gives high byte.
// - Justification sampled at read time.
// - Right: fill then top nibble; left: zero tail.
// - 12-bit mode presents all twelve bits at once.
// - Held start strobe restarts a conversion once each output enable toggle re-arms the update.
package adc_bus_pkg;
    localparam int CLOCK_MHZ = 50;
    localparam int RES_W = 12;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int CONV_TIME_NS = 4470;
    localparam int UPDATE_DELAY_NS = 200;
    localparam int CONV_CYCLES = (CONV_TIME_NS * CLOCK_MHZ) / 1000;
    localparam int UPDATE_CYCLES = (UPDATE_DELAY_NS * CLOCK_MHZ) / 1000;
    localparam int CNT_W = 16;
    localparam logic [RES_W-1:0] RESULT_RESET = 12'h000;
    localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
    localparam int SIGN_BIT = RES_W - 1;
    localparam int BIT_RL = 1;
    localparam int BIT_HBE = 0;
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_UPDATE} conv_state_e;
endpackage

// file: src/result_formatter.sv
`timescale 1ns/1ns
module result_formatter
    import adc_bus_pkg::*;
(
    input wire logic [adc_bus_pkg::RES_W-1:0] result,
    input wire logic bipolar,
    input wire logic right_justify,
    input wire logic upper_byte_select_n,
    output logic [adc_bus_pkg::BYTE_W-1:0] byte_out
);
    import adc_bus_pkg::*;

    logic [NIB_W-1:0] fill;

    // Bipolar fill copies the sign so the byte pair reads as 16-bit.
    assign fill = bipolar ? {NIB_W{result[SIGN_BIT]}} : NIB_ZERO;

    always_comb begin
        if (right_justify) begin
            if (!upper_byte_select_n) begin
                byte_out = {fill, result[RES_W-1 -: NIB_W]};
            end else begin
                byte_out = result[BYTE_W-1:0];
            end
        end else begin
            if (!upper_byte_select_n) begin
                byte_out = result[RES_W-1 -: BYTE_W];
            end else begin
                byte_out = {result[NIB_W-1:0], NIB_ZERO};
            end
        end
    end
endmodule

// file: src/sampling_adc_bus_interface.sv
`timescale 1ns/1ns
module sampling_adc_bus_interface
    import adc_bus_pkg::*;
#(
    parameter logic [adc_bus_pkg::CNT_W-1:0] CONV_COUNT =
        16'(adc_bus_pkg::CONV_CYCLES),
    parameter logic [adc_bus_pkg::CNT_W-1:0] UPDATE_COUNT =
        16'(adc_bus_pkg::UPDATE_CYCLES)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clocked_gating_mode,
    input wire logic chip_select_n,
    input wire logic conv_start_n,
    input wire logic done_flag_enable_n,
    input wire logic output_enable_n,
    input wire logic word_mode,
    input wire logic bipolar_offset_input,
    input wire logic [adc_bus_pkg::RES_W-1:0] sample_code,
    input wire logic [adc_bus_pkg::RES_W-1:0] result_bits_in,
    output logic [adc_bus_pkg::RES_W-1:0] result_bits_out,
    output logic [adc_bus_pkg::RES_W-1:0] result_bits_oe,
    output logic conv_done_out,
    output logic conv_done_oe,
    output logic converting
);
    import adc_bus_pkg::*;

    conv_state_e state_reg, state_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic [RES_W-1:0] result_reg, result_next;
    logic [RES_W-1:0] pending_reg, pending_next;
    logic start_prev_reg, start_prev_next;
    logic oe_prev_reg, oe_prev_next;
    logic armed_reg, armed_next;
    logic [RES_W-1:0] data_reg, data_next;
    logic read_en_reg, read_en_next;
    logic start_fall;
    logic start_req;
    logic read_en;
    logic [BYTE_W-1:0] byte_val;

    assign start_fall = start_prev_reg && !conv_start_n;
    // A held-low strobe restarts only when armed_reg is set, i.e. after reset or an output enable rise.
    assign start_req = (start_fall || (!conv_start_n && armed_reg)) &&
        (!clocked_gating_mode || !chip_select_n);
    assign read_en = !(chip_select_n || output_enable_n);

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        result_next = result_reg;
        pending_next = pending_reg;
        start_prev_next = conv_start_n;
        oe_prev_next = output_enable_n;
        armed_next = armed_reg;
        // Rising output enable marks the toggle that permits an update.
        if (output_enable_n && !oe_prev_reg) begin
            armed_next = 1'b1;
        end
        case (state_reg)
            ST_IDLE: begin
                if (start_req) begin
                    state_next = ST_CONVERT;
                    count_next = CONV_COUNT;
                    pending_next = sample_code;
                end
            end
            ST_CONVERT: begin
                if (count_reg <= 16'h0001) begin
                    state_next = ST_UPDATE;
                    count_next = UPDATE_COUNT;
                end else begin
                    count_next = count_reg - 16'h0001;
                end
            end
            ST_UPDATE: begin
                if (count_reg <= 16'h0001) begin
                    state_next = ST_IDLE;
                    if (armed_next) begin
                        result_next = pending_reg;
                        armed_next = 1'b0;
                    end
                end else begin
                    count_next = count_reg - 16'h0001;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            count_reg <= 16'h0000;
            result_reg <= RESULT_RESET;
            pending_reg <= RESULT_RESET;
            start_prev_reg <= 1'b1;
            oe_prev_reg <= 1'b1;
            armed_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            result_reg <= result_next;
            pending_reg <= pending_next;
            start_prev_reg <= start_prev_next;
            oe_prev_reg <= oe_prev_next;
            armed_reg <= armed_next;
        end
    end

    result_formatter u_fmt (
        .result(result_reg),
        .bipolar(bipolar_offset_input),
        .right_justify(result_bits_in[BIT_RL]),
        .upper_byte_select_n(result_bits_in[BIT_HBE]),
        .byte_out(byte_val)
    );

    always_comb begin
        read_en_next = read_en;
        if (word_mode) begin
            data_next = result_reg;
        end else begin
            data_next = {byte_val, NIB_ZERO};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            data_reg <= RESULT_RESET;
            read_en_reg <= 1'b0;
        end else begin
            data_reg <= data_next;
            read_en_reg <= read_en_next;
        end
    end

    assign result_bits_out = data_reg;
    genvar gi;
    generate
        for (gi = 0; gi < RES_W; gi++) begin : g_oe
            if (gi >= NIB_W) begin : g_hi
                assign result_bits_oe[gi] = read_en_reg;
            end else if (gi > BIT_RL) begin : g_mid
                assign result_bits_oe[gi] = read_en_reg && word_mode;
            end else begin : g_lo
                assign result_bits_oe[gi] = read_en_reg && word_mode;
            end
        end
    endgenerate

    assign converting = (state_reg == ST_CONVERT);
    always_comb begin
        if (clocked_gating_mode) begin
            conv_done_out = !converting;
            conv_done_oe = !chip_select_n && !done_flag_enable_n;
        end else begin
            conv_done_out = 1'b0;
            conv_done_oe = converting && !done_flag_enable_n;
        end
    end

    // The steps of one conversion, from accepted start back to rest.
    sequence s_start_taken;
        state_reg == ST_IDLE && start_req;
    endsequence

    sequence s_convert_entered;
        state_reg == ST_CONVERT && count_reg == CONV_COUNT;
    endsequence

    sequence s_convert_last;
        state_reg == ST_CONVERT && count_reg <= 16'h0001;
    endsequence

    sequence s_update_entered;
        state_reg == ST_UPDATE && count_reg == UPDATE_COUNT;
    endsequence

    sequence s_update_last;
        state_reg == ST_UPDATE && count_reg <= 16'h0001;
    endsequence

    sequence s_back_idle;
        state_reg == ST_IDLE;
    endsequence

    property p_conv_len;
        @(posedge clock) disable iff (rst)
        $rose(converting) |-> converting [*2];
    endproperty

    property p_start_enters;
        @(posedge clock) disable iff (rst)
        s_start_taken |=> s_convert_entered;
    endproperty

    property p_convert_to_update;
        @(posedge clock) disable iff (rst)
        s_convert_last |=> s_update_entered;
    endproperty

    property p_update_to_idle;
        @(posedge clock) disable iff (rst)
        s_update_last |=> s_back_idle;
    endproperty

    AST_START_GATE: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg == ST_IDLE && clocked_gating_mode && chip_select_n)
        |=> state_reg == ST_IDLE)
        else $error("start despite select");
    AST_START_ENTER: assert property (p_start_enters)
        else $error("start not taken");
    AST_FREE_RUN: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg == ST_IDLE && armed_reg && !conv_start_n &&
        !clocked_gating_mode) |=> state_reg == ST_CONVERT)
        else $error("held strobe did not restart");
    AST_CONV_HOLD: assert property (p_conv_len)
        else $error("conversion too short");
    AST_CONV_STEP: assert property (p_convert_to_update)
        else $error("update delay not entered");
    AST_UPDATE_END: assert property (p_update_to_idle)
        else $error("update delay not ended");
    AST_DONE_LOW: assert property (
        @(posedge clock) disable iff (rst)
        (converting && clocked_gating_mode && conv_done_oe)
        |-> !conv_done_out)
        else $error("conv_done high");
    AST_DONE_HIGH: assert property (
        @(posedge clock) disable iff (rst)
        (!converting && clocked_gating_mode && conv_done_oe)
        |-> conv_done_out)
        else $error("conv_done low while idle");
    AST_OPEN_DRAIN: assert property (
        @(posedge clock) disable iff (rst)
        !clocked_gating_mode |-> (conv_done_oe == (converting &&
        !done_flag_enable_n)))
        else $error("open drain bad");
    AST_OD_LEVEL: assert property (
        @(posedge clock) disable iff (rst)
        !clocked_gating_mode |-> !conv_done_out)
        else $error("open drain drives high");
    AST_TRI: assert property (
        @(posedge clock) disable iff (rst)
        (clocked_gating_mode && chip_select_n) |-> !conv_done_oe)
        else $error("conv_done driven");
    AST_DONE_DRIVEN: assert property (
        @(posedge clock) disable iff (rst)
        (clocked_gating_mode && !chip_select_n && !done_flag_enable_n)
        |-> conv_done_oe)
        else $error("conv_done not driven");
    AST_DATA_Z: assert property (
        @(posedge clock) disable iff (rst)
        $past(chip_select_n) |-> result_bits_oe == '0)
        else $error("data driven");
    AST_DATA_ON: assert property (
        @(posedge clock) disable iff (rst)
        read_en_reg |-> &result_bits_oe[RES_W-1:NIB_W])
        else $error("upper data not driven");
    AST_HOLD_OLD: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg == ST_CONVERT) |=> $stable(result_reg))
        else $error("early load");
    AST_LOAD_SLOT: assert property (
        @(posedge clock) disable iff (rst)
        $changed(result_reg) |-> $past(state_reg) == ST_UPDATE)
        else $error("load outside update delay");
    AST_LOAD_ARMED: assert property (
        @(posedge clock) disable iff (rst)
        $changed(result_reg) |->
        $past(armed_reg || (output_enable_n && !oe_prev_reg)))
        else $error("load without enable toggle");
    AST_LOW_PINS: assert property (
        @(posedge clock) disable iff (rst)
        !word_mode |-> result_bits_oe[BIT_RL:BIT_HBE] == 2'b00)
        else $error("format pins driven");
    AST_BYTE_TAIL: assert property (
        @(posedge clock) disable iff (rst)
        $past(!word_mode) |-> result_bits_out[NIB_W-1:0] == NIB_ZERO)
        else $error("low nibble not clear");
    AST_WORD_DATA: assert property (
        @(posedge clock) disable iff (rst)
        $past(word_mode) |-> result_bits_out == $past(result_reg))
        else $error("word data wrong");
endmodule

// file: verif/host_bus_model.sv
`timescale 1ns/1ns
module host_bus_model
    import adc_bus_pkg::*;
(
    input wire logic [adc_bus_pkg::RES_W-1:0] result_bits_out,
    input wire logic [adc_bus_pkg::RES_W-1:0] result_bits_oe,
    input wire logic [1:0] format_select,
    input wire logic conv_done_out,
    input wire logic conv_done_oe,
    output logic [adc_bus_pkg::RES_W-1:0] bus,
    output logic done_wire
);
    always_comb begin
        // Undriven lines rest at the pull-up level, except bits 1:0, which carry format_select.
        bus = {RES_W{1'b1}};
        bus[1:0] = format_select;
        for (int i = 0; i < RES_W; i++) begin
            if (result_bits_oe[i]) begin
                bus[i] = result_bits_out[i];
            end
        end
        // The done line carries an external pull-up in both gating modes.
        done_wire = conv_done_oe ? conv_done_out : 1'b1;
    end
endmodule

// file: verif/test_sampling_adc_bus_interface.sv
`timescale 1ns/1ns
module test_sampling_adc_bus_interface;
    import adc_bus_pkg::*;
    // Start spacing is scaled down along with the shortened conversion count.
    localparam int MIN_GAP = 8;
    logic clock = 1'b0, rst = 1'b1, mode = 1'b0, cs_n = 1'b1, sc_n = 1'b1;
    logic den_n = 1'b1, oe_n = 1'b1, word = 1'b1, bip = 1'b0;
    logic [RES_W-1:0] code = 12'h000;
    logic [1:0] fmt = 2'h0;
    logic [RES_W-1:0] bus, dout, doe;
    logic dval, doen, conv, done_wire;
    int err_count = 0;
    int checks = 0;
    always #10 clock = ~clock;
    sampling_adc_bus_interface #(.CONV_COUNT(16'h0004),
        .UPDATE_COUNT(16'h0002)) DUT (.clock(clock), .rst(rst),
        .clocked_gating_mode(mode), .chip_select_n(cs_n),
        .conv_start_n(sc_n), .done_flag_enable_n(den_n),
        .output_enable_n(oe_n), .word_mode(word),
        .bipolar_offset_input(bip), .sample_code(code),
        .result_bits_in(bus), .result_bits_out(dout), .result_bits_oe(doe),
        .conv_done_out(dval), .conv_done_oe(doen), .converting(conv));
    host_bus_model host (.result_bits_out(dout), .result_bits_oe(doe),
        .format_select(fmt), .conv_done_out(dval), .conv_done_oe(doen),
        .bus(bus), .done_wire(done_wire));
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic check(input logic [RES_W-1:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic start(input logic go, input logic done);
        int i;
        sc_n = 1'b0;
        step(1);
        sc_n = 1'b1;
        step(1);
        check({11'h000, conv}, {11'h000, go});
        check({11'h000, done_wire}, {11'h000, done});
        if (go) begin
            code = ~code;
        end
        for (i = 0; i < 20 && conv !== 1'b0; i++) begin
            step(1);
        end
        if (i == 20) begin
            err_count++;
            final_report();
        end
        check({11'h000, done_wire}, 12'h001);
        step(MIN_GAP);
    endtask
    task automatic read(input logic [1:0] f, input logic [RES_W-1:0] eo, ex);
        cs_n = 1'b0;
        oe_n = 1'b0;
        fmt = f;
        step(2);
        check(doe, eo);
        check(bus, ex);
        oe_n = 1'b1;
        step(2);
        check(doe, 12'h000);
    endtask
    task automatic t_word();
        code = 12'hab5;
        start(1'b1, 1'b1);
        read(2'h0, 12'hfff, 12'hab5);
        $display("test word read done");
    endtask
    task automatic t_byte();
        logic [1:0] f [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
        logic [RES_W-1:0] e [4] = '{12'hf9e, 12'hc3f, 12'h9cc, 12'h30d};
        word = 1'b0;
        bip = 1'b1;
        code = 12'h9c3;
        start(1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            read(f[i], 12'hff0, e[i] | {10'h000, f[i]});
        end
        bip = 1'b0;
        read(2'h2, 12'hff0, 12'h09e);
        $display("test byte read done");
    endtask
    task automatic t_gate();
        word = 1'b1;
        mode = 1'b1;
        cs_n = 1'b1;
        code = 12'h5a5;
        start(1'b0, 1'b1);
        cs_n = 1'b0;
        den_n = 1'b0;
        start(1'b1, 1'b0);
        mode = 1'b0;
        den_n = 1'b1;
        cs_n = 1'b1;
        code = 12'h123;
        start(1'b1, 1'b1);
        read(2'h0, 12'hfff, 12'h5a5);
        $display("test gating done");
    endtask
    initial begin
        step(4);
        rst = 1'b0;
        step(1);
        cs_n = 1'b0;
        t_word();
        t_byte();
        t_gate();
        final_report();
    end
endmodule
